// ---- logic/scpi_cfg.svh ----
// constants for the command-tree parser: characters, sizes, reset values
// assumes one 100 MHz clock; no timing counts are needed by this block
`ifndef SCPI_CFG_SVH
`define SCPI_CFG_SVH

// message characters
`define CH_NL 8'h0a
`define CH_SPACE 8'h20
`define CH_STAR 8'h2a
`define CH_COLON 8'h3a
`define CH_SEMI 8'h3b
`define CH_QMARK 8'h3f
`define CH_ZERO 8'h30
`define CH_NINE 8'h39
`define CH_UP_A 8'h41
`define CH_UP_Z 8'h5a
`define CH_LO_A 8'h61
`define CH_LO_Z 8'h7a
`define CH_CASE_BIT 8'h20

// header word buffer: characters and bits
`define WORD_CHARS 12
`define WORD_BITS 96
`define WLEN_BITS 4
`define COMMON_CHARS 4'h3

// parameter and level widths
`define PARAM_BITS 16
`define PARAM_RADIX 16'h000a
`define LEVEL_RESET 16'h0000

// bus address, settable from the panel only
`define ADDR_BITS 5
`define ADDR_RESET 5'h05

`endif

// ---- logic/scpi_pkg.sv ----
// types for the command-tree parser: keywords, tree nodes, parser state
// assumes scpi_cfg.svh is on the include path
package scpi_pkg;
`include "scpi_cfg.svh"

typedef enum logic [1:0] {
    ST_UNIT = 2'b00,
    ST_HDR = 2'b01,
    ST_PARAM = 2'b10,
    ST_SKIP = 2'b11
} pstate_t;

typedef enum logic [3:0] {
    KW_NONE = 4'h0,
    KW_STAT = 4'h1,
    KW_OPER = 4'h2,
    KW_QUES = 4'h3,
    KW_EVEN = 4'h4,
    KW_COND = 4'h5,
    KW_ENAB = 4'h6,
    KW_OUTP = 4'h7,
    KW_PROT = 4'h8,
    KW_CLE = 4'h9,
    KW_SOUR = 4'ha,
    KW_VOLT = 4'hb,
    KW_CURR = 4'hc,
    KW_LEV = 4'hd,
    KW_IMM = 4'he,
    KW_TRIG = 4'hf
} kw_t;

typedef enum logic [4:0] {
    N_NONE = 5'h00,
    N_ROOT = 5'h01,
    N_STAT = 5'h02,
    N_OPER = 5'h03,
    N_QUES = 5'h04,
    N_OPER_EVEN = 5'h05,
    N_OPER_COND = 5'h06,
    N_OPER_ENAB = 5'h07,
    N_QUES_EVEN = 5'h08,
    N_OUTP = 5'h09,
    N_OUTP_STATE = 5'h0a,
    N_OUTP_PROT = 5'h0b,
    N_PROT_CLE = 5'h0c,
    N_SOUR = 5'h0d,
    N_VOLT = 5'h0e,
    N_VOLT_LEV = 5'h0f,
    N_VOLT_IMM = 5'h10,
    N_VOLT_TRIG = 5'h11,
    N_VOLT_PROT = 5'h12,
    N_CURR = 5'h13,
    N_CURR_LEV = 5'h14,
    N_CURR_IMM = 5'h15,
    N_CURR_TRIG = 5'h16
} node_t;

typedef struct packed {
    pstate_t st;
    node_t path;
    node_t base;
    node_t cur;
    logic [`WORD_BITS-1:0] word;
    logic [`WLEN_BITS-1:0] wlen;
    logic is_common;
    logic query;
    logic have;
    logic [`PARAM_BITS-1:0] param;
    logic cmd_valid;
    node_t cmd_node;
    logic cmd_query;
    logic [`PARAM_BITS-1:0] cmd_param;
    logic common_valid;
    logic [23:0] common_name;
    logic err;
    logic qint;
    logic [`ADDR_BITS-1:0] bus_addr;
} parser_t;

endpackage

// ---- logic/scpi_tree_parser.sv ----
// command-tree parser: one byte per cycle, header path, unit decode
// assumes bytes, end flag, device clear and panel writes share i_sys_clk
// Notes on behaviour
// - at reset the active header path sits at the root node
// - a device clear from the bus returns the path to root
// - end of program message puts the path back at root
// - colon before first header of a unit resets path to root
// - at root a root-level header needs no leading colon
// - accepting a non-terminal header moves the path one level down
// - explicit final header leaves path at its level for siblings
// - omitted optional headers implied; path returns to the level of the last explicit header
// - source header optional before current and voltage subsystems
// - only children of the current path are searched, no tree walk
// - common command is asterisk plus three letters or digits, query and parameter
// - common commands run anywhere and leave the path unchanged
// - new input while a response is unread flags query interrupted
// - unwritten trigger level tracks immediate level, then stays apart
// - everything is bus controlled except the address, panel only
// - newline, end flag or both terminate the message
// - headers match in any case, long or short form only
module scpi_tree_parser
    import scpi_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // received program bytes
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_end,
    input wire logic i_dev_clear,
    // response queue state
    input wire logic i_resp_pending,
    // front panel address entry
    input wire logic i_panel_addr_we,
    input wire logic [`ADDR_BITS-1:0] i_panel_addr,
    // decoded commands
    output logic o_cmd_valid,
    output node_t o_cmd_node,
    output logic o_cmd_query,
    output logic [`PARAM_BITS-1:0] o_cmd_param,
    output logic o_common_valid,
    output logic [23:0] o_common_name,
    output logic o_cmd_err,
    output logic o_query_intr,
    output node_t o_path,
    // settings
    output logic [`ADDR_BITS-1:0] o_bus_addr,
    output logic [`PARAM_BITS-1:0] o_volt_imm,
    output logic [`PARAM_BITS-1:0] o_volt_trig,
    output logic [`PARAM_BITS-1:0] o_curr_imm,
    output logic [`PARAM_BITS-1:0] o_curr_trig
);

    function automatic logic [7:0] upcase(input logic [7:0] c);
        if (c >= `CH_LO_A && c <= `CH_LO_Z) begin
            return c & ~`CH_CASE_BIT;
        end
        return c;
    endfunction

    function automatic logic is_letter(input logic [7:0] c);
        return c >= `CH_UP_A && c <= `CH_UP_Z;
    endfunction

    function automatic logic is_digit(input logic [7:0] c);
        return c >= `CH_ZERO && c <= `CH_NINE;
    endfunction

    // exact long or short form only; the word is zero padded on the left
    function automatic kw_t kw_decode(input logic [`WORD_BITS-1:0] w);
        case (w)
            96'("STATUS"), 96'("STATE"), 96'("STAT"): return KW_STAT;
            96'("OPERATION"), 96'("OPER"): return KW_OPER;
            96'("QUESTIONABLE"), 96'("QUES"): return KW_QUES;
            96'("EVENT"), 96'("EVEN"): return KW_EVEN;
            96'("CONDITION"), 96'("COND"): return KW_COND;
            96'("ENABLE"), 96'("ENAB"): return KW_ENAB;
            96'("OUTPUT"), 96'("OUTP"): return KW_OUTP;
            96'("PROTECTION"), 96'("PROT"): return KW_PROT;
            96'("CLEAR"), 96'("CLE"): return KW_CLE;
            96'("SOURCE"), 96'("SOUR"): return KW_SOUR;
            96'("VOLTAGE"), 96'("VOLT"): return KW_VOLT;
            96'("CURRENT"), 96'("CURR"): return KW_CURR;
            96'("LEVEL"), 96'("LEV"): return KW_LEV;
            96'("IMMEDIATE"), 96'("IMM"): return KW_IMM;
            96'("TRIGGERED"), 96'("TRIG"): return KW_TRIG;
            default: return KW_NONE;
        endcase
    endfunction

    // children of one node only: no search elsewhere in the tree
    function automatic node_t tree_child(input node_t n, input kw_t k);
        node_t r;
        r = N_NONE;
        unique case (n)
            N_ROOT: begin
                if (k == KW_STAT) r = N_STAT;
                if (k == KW_OUTP) r = N_OUTP;
                if (k == KW_SOUR) r = N_SOUR;
                if (k == KW_VOLT) r = N_VOLT;
                if (k == KW_CURR) r = N_CURR;
            end
            N_STAT: begin
                if (k == KW_OPER) r = N_OPER;
                if (k == KW_QUES) r = N_QUES;
            end
            N_OPER: begin
                if (k == KW_EVEN) r = N_OPER_EVEN;
                if (k == KW_COND) r = N_OPER_COND;
                if (k == KW_ENAB) r = N_OPER_ENAB;
            end
            N_QUES: begin
                if (k == KW_EVEN) r = N_QUES_EVEN;
            end
            N_OUTP: begin
                if (k == KW_STAT) r = N_OUTP_STATE;
                if (k == KW_PROT) r = N_OUTP_PROT;
            end
            N_OUTP_PROT: begin
                if (k == KW_CLE) r = N_PROT_CLE;
            end
            N_SOUR: begin
                if (k == KW_VOLT) r = N_VOLT;
                if (k == KW_CURR) r = N_CURR;
            end
            N_VOLT: begin
                if (k == KW_LEV) r = N_VOLT_LEV;
                if (k == KW_PROT) r = N_VOLT_PROT;
            end
            N_VOLT_LEV: begin
                if (k == KW_IMM) r = N_VOLT_IMM;
                if (k == KW_TRIG) r = N_VOLT_TRIG;
            end
            N_CURR: begin
                if (k == KW_LEV) r = N_CURR_LEV;
            end
            N_CURR_LEV: begin
                if (k == KW_IMM) r = N_CURR_IMM;
                if (k == KW_TRIG) r = N_CURR_TRIG;
            end
            default: r = N_NONE;
        endcase
        return r;
    endfunction

    // optional headers below the last explicit one are assumed present
    function automatic node_t implied_leaf(input node_t n);
        unique case (n)
            N_OPER: return N_OPER_EVEN;
            N_QUES: return N_QUES_EVEN;
            N_OUTP: return N_OUTP_STATE;
            N_VOLT, N_VOLT_LEV: return N_VOLT_IMM;
            N_CURR, N_CURR_LEV: return N_CURR_IMM;
            default: return n;
        endcase
    endfunction

    parser_t s_r;
    parser_t s_nxt;

    always_comb begin
        logic [7:0] c;
        logic term;
        logic hdr_end;
        logic fin;
        logic bad;
        node_t child;
        c = upcase(i_rx_data);
        term = 1'b0;
        hdr_end = 1'b0;
        fin = 1'b0;
        bad = 1'b0;
        child = N_NONE;
        s_nxt = s_r;
        s_nxt.cmd_valid = 1'b0;
        s_nxt.common_valid = 1'b0;
        s_nxt.err = 1'b0;
        s_nxt.qint = 1'b0;
        // address changes only from the panel, never from a bus command
        if (i_panel_addr_we) begin
            s_nxt.bus_addr = i_panel_addr;
        end
        if (i_dev_clear) begin
            s_nxt.st = ST_UNIT;
            s_nxt.path = N_ROOT;
            s_nxt.wlen = '0;
            s_nxt.word = '0;
            s_nxt.is_common = 1'b0;
            s_nxt.query = 1'b0;
            s_nxt.have = 1'b0;
            s_nxt.param = '0;
        end else if (i_rx_valid) begin
            // queue discards its unread data on this pulse
            s_nxt.qint = i_resp_pending;
            term = (i_rx_data == `CH_NL) || i_rx_end;
            unique case (s_r.st)
                ST_UNIT: begin
                    if (c == `CH_COLON) begin
                        s_nxt.path = N_ROOT;
                        s_nxt.st = ST_HDR;
                    end else if (c == `CH_STAR) begin
                        s_nxt.is_common = 1'b1;
                        s_nxt.st = ST_HDR;
                    end else if (is_letter(c)) begin
                        // path kept: at root this is an implied colon
                        s_nxt.word = {s_r.word[`WORD_BITS-9:0], c};
                        s_nxt.wlen = `WLEN_BITS'(1);
                        s_nxt.st = ST_HDR;
                    end else if (c != `CH_SEMI && c != `CH_SPACE && !term) begin
                        bad = 1'b1;
                    end
                end
                ST_HDR: begin
                    if (is_letter(c) || is_digit(c)) begin
                        if (s_r.query || s_r.wlen == `WLEN_BITS'(`WORD_CHARS)) begin
                            bad = 1'b1;
                        end else begin
                            s_nxt.word = {s_r.word[`WORD_BITS-9:0], c};
                            s_nxt.wlen = s_r.wlen + `WLEN_BITS'(1);
                        end
                    end else if (c == `CH_COLON) begin
                        hdr_end = 1'b1;
                        bad = s_r.wlen == '0 || s_r.is_common || s_r.query;
                    end else if (c == `CH_QMARK) begin
                        hdr_end = 1'b1;
                        bad = s_r.query;
                        s_nxt.query = 1'b1;
                    end else if (c == `CH_SPACE) begin
                        hdr_end = 1'b1;
                        s_nxt.st = ST_PARAM;
                    end else if (c == `CH_SEMI) begin
                        hdr_end = 1'b1;
                        fin = 1'b1;
                    end else if (!term) begin
                        bad = 1'b1;
                    end
                    if (term) begin
                        hdr_end = 1'b1;
                        fin = 1'b1;
                    end
                end
                ST_PARAM: begin
                    if (is_digit(c)) begin
                        s_nxt.param = `PARAM_BITS'(s_r.param * `PARAM_RADIX
                            + `PARAM_BITS'(c - `CH_ZERO));
                    end
                    fin = (c == `CH_SEMI) || term;
                end
                ST_SKIP: begin
                    // rest of a faulty unit is thrown away
                    if (c == `CH_SEMI) begin
                        s_nxt.st = ST_UNIT;
                    end
                end
            endcase
            if (hdr_end && !bad && s_nxt.wlen != '0) begin
                if (s_r.is_common) begin
                    bad = s_nxt.wlen != `COMMON_CHARS;
                    s_nxt.have = 1'b1;
                end else begin
                    child = tree_child(s_r.path, kw_decode(s_nxt.word));
                    if (child == N_NONE) begin
                        bad = 1'b1;
                    end else begin
                        s_nxt.base = s_r.path;
                        s_nxt.path = child;
                        s_nxt.cur = child;
                        s_nxt.have = 1'b1;
                        s_nxt.word = '0;
                        s_nxt.wlen = '0;
                    end
                end
            end
            if (bad) begin
                // restart from root so the next unit resolves predictably
                s_nxt.err = 1'b1;
                s_nxt.st = (c == `CH_SEMI) ? ST_UNIT : ST_SKIP;
                s_nxt.path = N_ROOT;
                s_nxt.have = 1'b0;
            end else if (fin && s_nxt.have) begin
                if (s_r.is_common) begin
                    s_nxt.common_valid = 1'b1;
                    s_nxt.common_name = s_nxt.word[23:0];
                end else begin
                    s_nxt.cmd_valid = 1'b1;
                    s_nxt.cmd_node = implied_leaf(s_nxt.cur);
                    // back to the level the last explicit header came from
                    s_nxt.path = s_nxt.base;
                end
                s_nxt.cmd_query = s_nxt.query;
                s_nxt.cmd_param = s_nxt.param;
            end
            if (fin || bad || term) begin
                s_nxt.word = '0;
                s_nxt.wlen = '0;
                s_nxt.is_common = 1'b0;
                s_nxt.query = 1'b0;
                s_nxt.have = 1'b0;
                s_nxt.param = '0;
                if (!bad) begin
                    s_nxt.st = ST_UNIT;
                end
            end
            if (term) begin
                s_nxt.path = N_ROOT;
                s_nxt.st = ST_UNIT;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            s_r <= '0;
            s_r.st <= ST_UNIT;
            s_r.path <= N_ROOT;
            s_r.base <= N_ROOT;
            s_r.cur <= N_ROOT;
            s_r.cmd_node <= N_NONE;
            s_r.bus_addr <= `ADDR_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // level writes from the registered command strobe
    logic wr_set;
    assign wr_set = s_r.cmd_valid && !s_r.cmd_query;

    trig_level_track u_volt (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_wr_imm(wr_set && s_r.cmd_node == N_VOLT_IMM),
        .i_wr_trig(wr_set && s_r.cmd_node == N_VOLT_TRIG),
        .i_data(s_r.cmd_param),
        .o_imm(o_volt_imm),
        .o_trig(o_volt_trig)
    );

    trig_level_track u_curr (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_wr_imm(wr_set && s_r.cmd_node == N_CURR_IMM),
        .i_wr_trig(wr_set && s_r.cmd_node == N_CURR_TRIG),
        .i_data(s_r.cmd_param),
        .o_imm(o_curr_imm),
        .o_trig(o_curr_trig)
    );

    assign o_cmd_valid = s_r.cmd_valid;
    assign o_cmd_node = s_r.cmd_node;
    assign o_cmd_query = s_r.cmd_query;
    assign o_cmd_param = s_r.cmd_param;
    assign o_common_valid = s_r.common_valid;
    assign o_common_name = s_r.common_name;
    assign o_cmd_err = s_r.err;
    assign o_query_intr = s_r.qint;
    assign o_path = s_r.path;
    assign o_bus_addr = s_r.bus_addr;

endmodule // scpi_tree_parser

// ---- logic/trig_level_track.sv ----
// one output level pair: immediate level and its trigger level
// assumes write strobes are one-cycle pulses on the system clock
module trig_level_track
    import scpi_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // writes
    input wire logic i_wr_imm,
    input wire logic i_wr_trig,
    input wire logic [`PARAM_BITS-1:0] i_data,
    // levels
    output logic [`PARAM_BITS-1:0] o_imm,
    output logic [`PARAM_BITS-1:0] o_trig
);

    typedef struct packed {
        logic [`PARAM_BITS-1:0] imm;
        logic [`PARAM_BITS-1:0] trig;
        logic programmed;
    } lvl_t;

    lvl_t s_r;
    lvl_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (i_wr_imm) begin
            s_nxt.imm = i_data;
            // unprogrammed trigger level follows the immediate one
            if (!s_r.programmed) begin
                s_nxt.trig = i_data;
            end
        end
        if (i_wr_trig) begin
            s_nxt.trig = i_data;
            s_nxt.programmed = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            s_r <= '{imm: `LEVEL_RESET, trig: `LEVEL_RESET, programmed: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_imm = s_r.imm;
    assign o_trig = s_r.trig;

endmodule // trig_level_track

// ---- tb/ctrl_model.sv ----
// bus controller model: sends program messages one byte per cycle
// assumes the parser samples bytes on the rising edge of i_sys_clk
module ctrl_model (
    input wire logic i_sys_clk,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    output logic o_rx_end
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data = 8'h00;
        o_rx_end = 1'b0;
    end
    // gap 0 sends back to back, else idle cycles between bytes
    task automatic send(input string s, input bit eoi, input int gap);
        for (int k = 0; k < s.len(); k++) begin
            @(negedge i_sys_clk);
            o_rx_valid = 1'b1;
            o_rx_data = s[k];
            o_rx_end = eoi && (k == s.len() - 1);
            if (gap > 0 || k == s.len() - 1) begin
                @(negedge i_sys_clk);
                o_rx_valid = 1'b0;
                o_rx_end = 1'b0;
                // released data never repeats the last byte
                o_rx_data = ~o_rx_data;
                repeat (gap) @(negedge i_sys_clk);
            end
        end
    endtask
endmodule // ctrl_model

// ---- tb/scpi_tree_parser_properties.sv ----
// checker for the command-tree parser, bound to its top module
// assumes one clock and a synchronous active-low reset
module scpi_tree_parser_properties
    import scpi_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_end,
    input wire logic i_dev_clear,
    input wire logic i_resp_pending,
    input wire logic i_panel_addr_we,
    input wire logic [4:0] i_panel_addr,
    input wire logic o_cmd_valid,
    input wire node_t o_cmd_node,
    input wire logic o_cmd_query,
    input wire logic o_common_valid,
    input wire logic o_query_intr,
    input wire node_t o_path,
    input wire logic [4:0] o_bus_addr,
    input wire logic [15:0] o_volt_imm,
    input wire logic [15:0] o_volt_trig
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    logic take;
    logic unit_end;
    logic qint_cause;
    logic unit_start_r;
    logic semi_r;
    logic trig_set_r;
    node_t unit_path_r;
    assign take = i_rx_valid && !i_dev_clear;
    assign unit_end = take && (i_rx_data == 8'h3b || i_rx_data == 8'h0a || i_rx_end);
    assign qint_cause = take && i_resp_pending;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n || i_dev_clear) begin
            unit_start_r <= 1'b1;
            semi_r <= 1'b0;
        end else if (i_rx_valid) begin
            unit_start_r <= unit_end;
            // a semicolon with end flag closes the message, not the unit
            semi_r <= i_rx_data == 8'h3b && !i_rx_end;
        end
        if (take && unit_start_r) begin
            unit_path_r <= o_path;
        end
        if (!i_rst_n) begin
            trig_set_r <= 1'b0;
        end else if (o_cmd_valid && o_cmd_node == N_VOLT_TRIG && !o_cmd_query) begin
            trig_set_r <= 1'b1;
        end
    end
    a_reset_root: assert property (
        $rose(i_rst_n) |-> o_path == N_ROOT) else $error("path not at root after reset");
    a_clear_root: assert property (
        i_dev_clear |=> o_path == N_ROOT) else $error("path not at root after clear");
    a_term_root: assert property (
        take && (i_rx_data == 8'h0a || i_rx_end) |=> o_path == N_ROOT)
        else $error("path not at root after terminator");
    a_colon_root: assert property (
        take && i_rx_data == 8'h3a && unit_start_r |=> o_path == N_ROOT)
        else $error("leading colon did not return to root");
    a_common_path: assert property (
        o_common_valid && semi_r |-> o_path == unit_path_r)
        else $error("common command moved the path");
    a_answer_time: assert property (
        o_cmd_valid || o_common_valid |-> $past(unit_end))
        else $error("unit completed without separator");
    a_query_intr: assert property (
        o_query_intr == $past(qint_cause)) else $error("query interrupt mismatch");
    a_addr_hold: assert property (
        !$stable(o_bus_addr) |-> $past(i_panel_addr_we)) else $error("address moved");
    a_addr_load: assert property (
        i_panel_addr_we |=> o_bus_addr == $past(i_panel_addr)) else $error("address not loaded");
    a_trig_track: assert property (
        !trig_set_r |-> o_volt_trig == o_volt_imm) else $error("trigger level not tracking");
endmodule // scpi_tree_parser_properties

bind scpi_tree_parser scpi_tree_parser_properties i_props (.i_sys_clk, .i_rst_n,
    .i_rx_valid, .i_rx_data, .i_rx_end, .i_dev_clear, .i_resp_pending, .i_panel_addr_we,
    .i_panel_addr, .o_cmd_valid, .o_cmd_node, .o_cmd_query, .o_common_valid,
    .o_query_intr, .o_path, .o_bus_addr, .o_volt_imm, .o_volt_trig);

// ---- tb/scpi_tree_parser_tb.sv ----
// self-checking bench for the command-tree parser
// assumes ctrl_model drives bytes; bench drives clear, panel and pending
module scpi_tree_parser_tb
    import scpi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0] kind;
        node_t node;
        logic query;
        logic [23:0] val;
    } ev_t;
    logic i_sys_clk, i_rst_n, i_rx_valid, i_rx_end, i_dev_clear, i_resp_pending;
    logic i_panel_addr_we, o_cmd_valid, o_cmd_query, o_common_valid, o_cmd_err;
    logic o_query_intr;
    logic [7:0] i_rx_data;
    logic [4:0] i_panel_addr, o_bus_addr;
    node_t o_cmd_node, o_path;
    logic [15:0] o_cmd_param, o_volt_imm, o_volt_trig, o_curr_imm, o_curr_trig;
    logic [23:0] o_common_name;
    ev_t exp_q[$];
    int n_fail = 0;
    int num_checks = 0;
    int qint_n = 0;
    int v, a;
    scpi_tree_parser i_scpi_tree_parser (.i_sys_clk, .i_rst_n, .i_rx_valid, .i_rx_data,
        .i_rx_end, .i_dev_clear, .i_resp_pending, .i_panel_addr_we, .i_panel_addr,
        .o_cmd_valid, .o_cmd_node, .o_cmd_query, .o_cmd_param, .o_common_valid,
        .o_common_name, .o_cmd_err, .o_query_intr, .o_path, .o_bus_addr, .o_volt_imm,
        .o_volt_trig, .o_curr_imm, .o_curr_trig);
    ctrl_model i_ctrl_model (.i_sys_clk, .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data),
        .o_rx_end(i_rx_end));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic note(input logic [1:0] k, input node_t n, input logic q,
        input logic [23:0] val);
        exp_q.push_back('{k, n, q, val});
    endtask
    // answer after one cycle, levels after two
    task automatic settle;
        repeat (3) @(negedge i_sys_clk);
    endtask
    task automatic give_verdict;
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    always @(negedge i_sys_clk) begin
        ev_t seen;
        if (o_query_intr === 1'b1) qint_n++;
        if (o_cmd_valid === 1'b1 || o_common_valid === 1'b1 || o_cmd_err === 1'b1) begin
            seen = '{2'd1, o_cmd_node, o_cmd_query, {8'h00, o_cmd_param}};
            if (o_common_valid === 1'b1) seen = '{2'd2, N_NONE, o_cmd_query, o_common_name};
            if (o_cmd_err === 1'b1) seen = '{2'd3, N_NONE, 1'b0, 24'h0};
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("Error %0t: unexpected result %h", $time, seen);
            end else begin
                chk(seen, exp_q.pop_front());
            end
        end
    end
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        n_fail++;
        $display("Error %0t: run timed out", $time);
        give_verdict();
    end
    initial begin
        i_rst_n = 1'b0;
        i_dev_clear = 1'b0;
        i_resp_pending = 1'b0;
        i_panel_addr_we = 1'b0;
        i_panel_addr = 5'h00;
        v = $urandom(95331);
        repeat (10) @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        @(negedge i_sys_clk);
        chk(32'(o_path), 32'(N_ROOT));
        chk(32'(o_bus_addr), 32'h5);
        note(1, N_VOLT_IMM, 0, 5);
        i_ctrl_model.send("VOLT 5\n", 0, 0);
        settle();
        chk(32'(o_path), 32'(N_ROOT));
        chk({o_volt_imm, o_volt_trig}, {16'h5, 16'h5});
        note(1, N_OPER_ENAB, 0, 18);
        i_ctrl_model.send("STAT:OPER:ENAB 18;", 0, 0);
        settle();
        chk(32'(o_path), 32'(N_OPER));
        note(1, N_OPER_COND, 1, 0);
        i_ctrl_model.send("cond?\n", 0, 1);
        note(1, N_OPER_EVEN, 1, 0);
        i_ctrl_model.send("STAT:OPER?;", 0, 0);
        settle();
        chk(32'(o_path), 32'(N_STAT));
        note(2, N_NONE, 0, "RST");
        i_ctrl_model.send("*RST;", 0, 2);
        settle();
        chk(32'(o_path), 32'(N_STAT));
        note(1, N_QUES_EVEN, 1, 0);
        i_ctrl_model.send("QUES?\n", 0, 0);
        note(1, N_PROT_CLE, 0, 0);
        note(1, N_CURR_IMM, 0, 7);
        i_ctrl_model.send("OUTP:PROT:CLE;:CURR 7", 1, 0);
        settle();
        chk(32'(o_path), 32'(N_ROOT));
        chk({o_curr_imm, o_curr_trig}, {16'h7, 16'h7});
        note(1, N_VOLT_TRIG, 0, 3);
        i_ctrl_model.send("source:voltage:level:triggered 3\n", 0, 0);
        note(1, N_VOLT_IMM, 0, 8);
        i_ctrl_model.send("VOLT:LEV 8\n", 0, 0);
        settle();
        chk({o_volt_imm, o_volt_trig}, {16'h8, 16'h3});
        note(3, N_NONE, 0, 0);
        note(1, N_VOLT_IMM, 0, 9);
        i_ctrl_model.send("VOLTA;VOLT 9\n", 0, 0);
        note(1, N_OPER_ENAB, 0, 1);
        note(3, N_NONE, 0, 0);
        i_ctrl_model.send("STAT:OPER:ENAB 1;QUES?\n", 0, 0);
        i_ctrl_model.send("STAT:", 0, 0);
        i_dev_clear = 1'b1;
        @(negedge i_sys_clk);
        i_dev_clear = 1'b0;
        chk(32'(o_path), 32'(N_ROOT));
        note(3, N_NONE, 0, 0);
        i_ctrl_model.send("OPER?\n", 0, 0);
        // controller sends while a response is still unread
        i_resp_pending = 1'b1;
        note(2, N_NONE, 1, "OPC");
        i_ctrl_model.send("*OPC?\n", 0, 0);
        i_resp_pending = 1'b0;
        settle();
        chk(qint_n, 6);
        a = $urandom_range(31);
        i_panel_addr = 5'(a);
        i_panel_addr_we = 1'b1;
        @(negedge i_sys_clk);
        i_panel_addr_we = 1'b0;
        chk(32'(o_bus_addr), 32'(a));
        for (int k = 0; k < 6; k++) begin
            v = $urandom_range(65535);
            note(1, N_VOLT_IMM, 0, 24'(v));
            i_ctrl_model.send($sformatf("volt %0d\n", v), k[0], $urandom_range(2));
            settle();
            chk({o_volt_imm, o_volt_trig}, {v[15:0], 16'h3});
        end
        chk(32'(o_bus_addr), 32'(a));
        for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(negedge i_sys_clk);
        if (exp_q.size() != 0) begin
            n_fail++;
            $display("Error %0t: results missing", $time);
        end
        give_verdict();
    end
endmodule // scpi_tree_parser_tb
